/* File: hdl/etc_map.vh */
// Register offsets, field positions, reset values and timing counts of the event timer block.
`ifndef ETC_MAP_VH
`define ETC_MAP_VH
`define ETC_OFS_T1CTL 16'h1f90
`define ETC_OFS_T2CTL 16'h1f94
`define ETC_OFS_CNTA 16'h1f98
`define ETC_OFS_CNTB 16'h1f9c
`define ETC_OFS_TIME0 16'h1fa0
`define ETC_OFS_TIME1 16'h1fa4
`define ETC_OFS_PWMCTL 16'h1fa8
`define ETC_OFS_STATUS 16'h1fac
`define ETC_CTL_RESET 8'h00
`define ETC_BIT_EN 7
`define ETC_BIT_UP 6
`define ETC_MODE_HI 5
`define ETC_MODE_LO 3
`define ETC_PRE_HI 2
`define ETC_PRE_LO 0
`define ETC_MODE_F4_UD 3'h0
`define ETC_MODE_F4_DIR 3'h2
`define ETC_MODE_EXT_DIR 3'h3
`define ETC_MODE_QUAD 3'h7
`define ETC_RES_NS 160
`define ETC_CLK_NS 20
`define ETC_BASE_DIV ((`ETC_RES_NS + `ETC_CLK_NS - 1) / `ETC_CLK_NS)
`define ETC_RESP_OKAY 2'h0
`define ETC_RESP_SLVERR 2'h2
`endif

/* File: hdl/etc_tick_gen.v */
// Clock source, prescaler and direction selection for one event timer.
`include "etc_map.vh"
module etc_tick_gen #(
	parameter BASE_DIV = `ETC_BASE_DIV,
	parameter HAS_DIV128 = 1
) (
	input wire clk_sys,
	input wire rst,
	input wire [7:0] ctl,
	input wire ext_clock,
	input wire ext_direction,
	output reg tick,
	output reg up
);
	wire [2:0] mode = ctl[`ETC_MODE_HI:`ETC_MODE_LO];
	wire [2:0] pre = ctl[`ETC_PRE_HI:`ETC_PRE_LO];
	reg clk_s1_q, clk_s2_q, clk_s3_q;
	reg dir_s1_q, dir_s2_q, dir_s3_q;
	reg [7:0] base_q;
	reg [7:0] pre_cnt_q;
	reg [7:0] pre_lim;
	reg src_ev;
	reg qd_up;
	wire clk_edge = clk_s2_q ^ clk_s3_q;
	wire dir_edge = dir_s2_q ^ dir_s3_q;
	wire base_ev = (base_q == BASE_DIV[7:0] - 8'h01);
	always @* begin
		case (pre)
			3'h7: pre_lim = HAS_DIV128 ? 8'h7f : 8'h3f;
			default: pre_lim = (8'h01 << pre) - 8'h01;
		endcase
	end
	always @* begin
		// Decoding a quadrature pair: direction follows which phase leads.
		qd_up = clk_edge ? (clk_s2_q != dir_s2_q) : (clk_s2_q == dir_s2_q);
		case (mode)
			`ETC_MODE_F4_UD, `ETC_MODE_F4_DIR: src_ev = base_ev;
			`ETC_MODE_QUAD: src_ev = clk_edge | dir_edge;
			3'h4, 3'h6: src_ev = base_ev; // Reserved codes fall back to f/4 and leave the clock pin free.
			default: src_ev = clk_edge;
		endcase
	end
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			clk_s1_q <= 1'b0;
			clk_s2_q <= 1'b0;
			clk_s3_q <= 1'b0;
			dir_s1_q <= 1'b0;
			dir_s2_q <= 1'b0;
			dir_s3_q <= 1'b0;
			base_q <= 8'h00;
			pre_cnt_q <= 8'h00;
			tick <= 1'b0;
			up <= 1'b0;
		end else begin
			clk_s1_q <= ext_clock;
			clk_s2_q <= clk_s1_q;
			clk_s3_q <= clk_s2_q;
			dir_s1_q <= ext_direction;
			dir_s2_q <= dir_s1_q;
			dir_s3_q <= dir_s2_q;
			base_q <= base_ev ? 8'h00 : base_q + 8'h01;
			tick <= 1'b0;
			if (!ctl[`ETC_BIT_EN]) begin
				pre_cnt_q <= 8'h00;
			end else if (src_ev) begin
				if (pre_cnt_q >= pre_lim) begin
					pre_cnt_q <= 8'h00;
					tick <= 1'b1;
				end else begin
					pre_cnt_q <= pre_cnt_q + 8'h01;
				end
			end
			case (mode)
				`ETC_MODE_F4_DIR, `ETC_MODE_EXT_DIR: up <= dir_s2_q;
				`ETC_MODE_QUAD: up <= qd_up;
				default: up <= ctl[`ETC_BIT_UP];
			endcase
		end
	end
endmodule // etc_tick_gen

/* File: hdl/etc_timer_top.v */
// Event timer pair with register slave and highest-speed paired-compare PWM.
// Functional notes
// - The first compare toggles the PWM output on a match; the second toggles it again and clears the timer.
// - The PWM runs in hardware with no interrupt or software step per period.
// - Successive compares on the f/4 clock are at least one timer resolution apart, 160 ns undivided; an external clock can tick every clock.
// - With timer 2 clocked from its external pin, channel 0 is unavailable.
// - With timer 2 directed from its external pin, channel 1 is unavailable.
// - Writing a count register with byte strobes 0 and 1 both set loads that value into its timer at once.
// - Mode bits 5:3 choose f/4 or external clock and the direction bit or direction pin.
// - An external clock counts on both its rising and falling edges.
// - Mode 111 counts in quadrature from the clock and direction pins.
// - Prescale bits 2:0 divide by two to their power, 128 only on the larger variant.
`include "etc_map.vh"
module etc_timer_top #(
	parameter HAS_DIV128 = 1,
	parameter BASE_DIV = `ETC_BASE_DIV
) (
	input wire clk_sys,
	input wire rst,
	input wire [15:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [15:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire count_a_ext_clock,
	input wire count_a_ext_direction,
	input wire count_b_ext_clock,
	input wire count_b_ext_direction,
	output reg pwm_out
);
	reg [7:0] count_a_control_q;
	reg [7:0] count_b_control_q;
	reg [15:0] count_a_q;
	reg [15:0] count_b_q;
	reg [15:0] time0_q;
	reg [15:0] time1_q;
	reg [1:0] pwm_ctl_q;
	reg [15:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg aw_have_q;
	reg w_have_q;
	reg [31:0] rd_mux;
	reg rd_ok;
	reg [15:0] wr_val;
	wire tick_a, tick_b, up_a, up_b;
	wire [2:0] t2_mode = count_b_control_q[`ETC_MODE_HI:`ETC_MODE_LO];
	// Timer 2 borrows the channel 0 and 1 pins when it uses its external clock or direction.
	wire ch0_blocked = (t2_mode == 3'h1) || (t2_mode == 3'h5) || (t2_mode == `ETC_MODE_EXT_DIR)
		|| (t2_mode == `ETC_MODE_QUAD);
	wire ch1_blocked = (t2_mode == `ETC_MODE_F4_DIR) || (t2_mode == `ETC_MODE_EXT_DIR)
		|| (t2_mode == `ETC_MODE_QUAD);
	wire pwm_en = pwm_ctl_q[0] & ~ch0_blocked & ~ch1_blocked;
	wire match0 = pwm_en & tick_a & (count_a_q == time0_q);
	wire match1 = pwm_en & tick_a & (count_a_q == time1_q);
	wire wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
	etc_tick_gen #(.BASE_DIV(BASE_DIV), .HAS_DIV128(HAS_DIV128)) u_gen_a (
		.clk_sys(clk_sys),
		.rst(rst),
		.ctl(count_a_control_q),
		.ext_clock(count_a_ext_clock),
		.ext_direction(count_a_ext_direction),
		.tick(tick_a),
		.up(up_a)
	);
	etc_tick_gen #(.BASE_DIV(BASE_DIV), .HAS_DIV128(HAS_DIV128)) u_gen_b (
		.clk_sys(clk_sys),
		.rst(rst),
		.ctl(count_b_control_q),
		.ext_clock(count_b_ext_clock),
		.ext_direction(count_b_ext_direction),
		.tick(tick_b),
		.up(up_b)
	);
	always @* begin
		wr_val = w_data_q[15:0];
		if (!w_strb_q[0]) begin
			wr_val[7:0] = 8'h00;
		end
		if (!w_strb_q[1]) begin
			wr_val[15:8] = 8'h00;
		end
	end
	always @* begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`ETC_OFS_T1CTL: rd_mux = {24'h000000, count_a_control_q};
			`ETC_OFS_T2CTL: rd_mux = {24'h000000, count_b_control_q};
			`ETC_OFS_CNTA: rd_mux = {16'h0000, count_a_q};
			`ETC_OFS_CNTB: rd_mux = {16'h0000, count_b_q};
			`ETC_OFS_TIME0: rd_mux = {16'h0000, time0_q};
			`ETC_OFS_TIME1: rd_mux = {16'h0000, time1_q};
			`ETC_OFS_PWMCTL: rd_mux = {30'h00000000, pwm_ctl_q};
			`ETC_OFS_STATUS: rd_mux = {28'h0000000, ch1_blocked, ch0_blocked, pwm_out, pwm_en};
			default: begin
				rd_mux = 32'h00000000;
				rd_ok = 1'b0;
			end
		endcase
	end
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ETC_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `ETC_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 16'h0000;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			count_a_control_q <= `ETC_CTL_RESET;
			count_b_control_q <= `ETC_CTL_RESET;
			count_a_q <= 16'h0000;
			count_b_q <= 16'h0000;
			time0_q <= 16'h0000;
			time1_q <= 16'h0000;
			pwm_ctl_q <= 2'h0;
			pwm_out <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// Timer 1 counts; a write to its count register overrides the same cycle's step.
			if (match1) begin
				count_a_q <= 16'h0000;
			end else if (tick_a) begin
				count_a_q <= up_a ? count_a_q + 16'h0001 : count_a_q - 16'h0001;
			end
			if (tick_b) begin
				count_b_q <= up_b ? count_b_q + 16'h0001 : count_b_q - 16'h0001;
			end
			// Both matches in one tick toggle twice, so the level is unchanged.
			if (match0 ^ match1) begin
				pwm_out <= ~pwm_out;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `ETC_RESP_OKAY;
				case (aw_addr_q)
					`ETC_OFS_T1CTL: begin
						if (w_strb_q[0]) begin
							count_a_control_q <= w_data_q[7:0];
						end
					end
					`ETC_OFS_T2CTL: begin
						if (w_strb_q[0]) begin
							count_b_control_q <= w_data_q[7:0];
						end
					end
					`ETC_OFS_CNTA: count_a_q <= (w_strb_q[1:0] == 2'h3) ? wr_val : count_a_q;
					`ETC_OFS_CNTB: count_b_q <= (w_strb_q[1:0] == 2'h3) ? wr_val : count_b_q;
					`ETC_OFS_TIME0: time0_q <= (w_strb_q[1:0] == 2'h3) ? wr_val : time0_q;
					`ETC_OFS_TIME1: time1_q <= (w_strb_q[1:0] == 2'h3) ? wr_val : time1_q;
					`ETC_OFS_PWMCTL: begin
						if (w_strb_q[0]) begin
							pwm_ctl_q <= w_data_q[1:0];
							if (w_data_q[1]) begin
								pwm_out <= 1'b0;
							end
						end
					end
					`ETC_OFS_STATUS: s_axi_bresp <= `ETC_RESP_OKAY;
					default: s_axi_bresp <= `ETC_RESP_SLVERR;
				endcase
			end
			// Read data is launched only after the address handshake, so rvalid never precedes it.
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_ok ? `ETC_RESP_OKAY : `ETC_RESP_SLVERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // etc_timer_top

/* File: dv/etc_checker.sv */
// Concurrent checks on the register bus handshake and the PWM output of the event timer.
module etc_checker (
	input wire clk_sys,
	input wire rst,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire pwm_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	a_aw_answer: assert property ($rose(s_axi_awvalid) |=> s_axi_awready) else $error("no awready");
	a_ready_pulse: assert property (s_axi_wready |=> !s_axi_wready) else $error("wready held");
	a_b_after: assert property (s_axi_awready |-> ##2 s_axi_bvalid) else $error("late bvalid");
	a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid held");
	a_r_answer: assert property ($rose(s_axi_arvalid) |=> s_axi_arready ##1 s_axi_rvalid) else $error("late read");
	a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid held");
	a_pwm_reset: assert property ($fell(rst) |-> !pwm_out) else $error("pwm high at reset");
	// With timer 1 on f/4 a compare can only fire once per timer resolution, so a high phase lasts at least eight clocks.
	a_pwm_space: assert property ($rose(pwm_out) |=> pwm_out[*7]) else $error("pwm edge too soon");
	c_pwm: cover property ($rose(pwm_out));
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // etc_checker

/* File: dv/etc_enc_model.sv */
// Behavioural encoder driving the timer's external clock and direction pins.
module etc_enc_model (
	input wire clk_sys,
	output logic ext_clock,
	output logic ext_direction
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {ext_clock, ext_direction} = 2'h0;
	// Pins stand still between runs; in quadrature the clock pin leads, which means counting up.
	task automatic run(input int edges, input bit quad, input int gap);
		for (int i = 0; i < edges; i++) begin
			repeat (gap) @(posedge clk_sys);
			if (quad && i % 2 == 1)
				ext_direction <= ~ext_direction;
			else
				ext_clock <= ~ext_clock;
		end
	endtask
endmodule // etc_enc_model

/* File: dv/testbench.sv */
// Self-checking bench for the event timer: counting modes, prescaler, pin sharing and fast PWM.
`include "etc_map.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0, rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, count_b_ext_clock = 1'b0, count_b_ext_direction = 1'b0;
	logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
	logic [31:0] s_axi_wdata = 32'h0, d;
	logic [3:0] s_axi_wstrb = 4'hf;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pwm_out, count_a_ext_clock;
	wire count_a_ext_direction;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	int errors = 0, n_compared = 0, c, k;
	logic [7:0] xc[3] = '{8'hc8, 8'h98, 8'hf8};
	logic [31:0] xe[3] = '{32'h6a, 32'h5e, 32'h6a};
	logic [2:0] tm[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
	etc_timer_top etc_timer_top_inst (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_a_ext_clock,
		.count_a_ext_direction, .count_b_ext_clock, .count_b_ext_direction, .pwm_out);
	etc_enc_model etc_enc_model_inst (.clk_sys, .ext_clock(count_a_ext_clock), .ext_direction(count_a_ext_direction));
	always #10 clk_sys = ~clk_sys;
	task wrap_up;
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("mismatch at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task chk_rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
		n_compared++;
		if ((g >= lo && g <= hi) !== 1'b1) begin
			errors++;
			$display("mismatch at %0t: got %h, expected %h to %h", $time, g, lo, hi);
		end
	endtask
	task tmo;
		errors++;
		wrap_up();
	endtask
	task automatic xfer(input bit w, input logic [15:0] a, input logic [31:0] v, input logic [1:0] e);
		int n;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, v};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
		{s_axi_arvalid, s_axi_rready} <= {2{!w}};
		for (n = 0; n < 50 && (w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1; n++) begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		d = s_axi_rdata;
		{s_axi_bready, s_axi_rready} <= 2'h0;
		if (n == 50) tmo();
		chk(w ? s_axi_bresp : s_axi_rresp, e);
		@(posedge clk_sys);
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		xfer(0, `ETC_OFS_T1CTL, 32'h0, 2'h0);
		chk(d, `ETC_CTL_RESET);
		xfer(0, 16'h1ff0, 32'h0, `ETC_RESP_SLVERR);
		chk(d, 32'h0);
		xfer(1, 16'h1ff0, 32'h1, `ETC_RESP_SLVERR);
		// Odd codes take direction from the pin, held low against an up bit of 1, so both count down.
		for (int p = 0; p < 8; p++) begin
			xfer(1, `ETC_OFS_T1CTL, 32'h80 + (p % 2) * 32'h50 + p, 2'h0);
			xfer(1, `ETC_OFS_CNTA, 32'h3e8, 2'h0);
			repeat (10 * (`ETC_BASE_DIV << p)) @(posedge clk_sys);
			xfer(0, `ETC_OFS_CNTA, 32'h0, 2'h0);
			chk_rng(d, 32'h3dc, 32'h3df);
		end
		for (int i = 0; i < 3; i++) begin
			xfer(1, `ETC_OFS_T1CTL, xc[i], 2'h0);
			xfer(1, `ETC_OFS_CNTA, 32'h64, 2'h0);
			etc_enc_model_inst.run(6, i == 2, 3 + 3 * i);
			repeat (8) @(posedge clk_sys);
			xfer(0, `ETC_OFS_CNTA, 32'h0, 2'h0);
			chk(d, xe[i]);
		end
		xfer(1, `ETC_OFS_TIME0, 32'h3, 2'h0);
		xfer(1, `ETC_OFS_TIME1, 32'h6, 2'h0);
		xfer(1, `ETC_OFS_CNTA, 32'h0, 2'h0);
		xfer(1, `ETC_OFS_PWMCTL, 32'h1, 2'h0);
		xfer(1, `ETC_OFS_T1CTL, 32'hc0, 2'h0);
		repeat (2) begin
			for (k = 0; k < 2000 && pwm_out !== 1'b1; k++) @(posedge clk_sys);
			for (c = 0; c < 2000 && pwm_out === 1'b1; c++) @(posedge clk_sys);
			if (k == 2000 || c == 2000) tmo();
			chk(c, 3 * `ETC_BASE_DIV);
		end
		// Clearing the output early in a high phase; the next compare lies 24 clocks after the rise.
		for (k = 0; k < 2000 && pwm_out !== 1'b1; k++) @(posedge clk_sys);
		if (k == 2000) tmo();
		repeat (10) @(posedge clk_sys);
		xfer(1, `ETC_OFS_PWMCTL, 32'h3, 2'h0);
		xfer(0, `ETC_OFS_STATUS, 32'h0, 2'h0);
		chk(d, 32'h1);
		// Timer 2 on its own clock pin counts both edges of four pin changes.
		xfer(1, `ETC_OFS_CNTB, 32'h10, 2'h0);
		xfer(1, `ETC_OFS_T2CTL, 32'hc8, 2'h0);
		repeat (4) begin
			repeat (4) @(posedge clk_sys);
			count_b_ext_clock <= ~count_b_ext_clock;
		end
		repeat (8) @(posedge clk_sys);
		xfer(0, `ETC_OFS_CNTB, 32'h0, 2'h0);
		chk(d, 32'h14);
		for (int i = 0; i < 6; i++) begin
			xfer(1, `ETC_OFS_T2CTL, {tm[i], 3'h0}, 2'h0);
			xfer(0, `ETC_OFS_STATUS, 32'h0, 2'h0);
			chk(d & 32'hd, {tm[i][1], tm[i][0], 1'b0, tm[i][1:0] == 2'h0});
		end
		// A second reset in mid-run must stop the timer and clear the output again.
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		chk(pwm_out, 1'b0);
		xfer(0, `ETC_OFS_T1CTL, 32'h0, 2'h0);
		chk(d, `ETC_CTL_RESET);
		wrap_up();
	end
endmodule // testbench
bind etc_timer_top etc_checker etc_checker_inst (.clk_sys, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .pwm_out);
